// file: hdl/fkls_top.sv
// flash key store and lock activation command handler
`timescale 1ns/1ps
`include "fkls_cfg.svh"

module fkls_top #(
  parameter int WORD_CYCLES = `FKLS_WORD_CYCLES
) (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_clk_en,
  input  wire logic [`FKLS_OP_W-1:0]     i_op_select,
  input  wire logic                      i_execute_trigger,
  input  wire logic [10:0]               i_ram_word_pointer,
  input  wire logic                      i_status_read,
  input  wire logic [31:0]               i_ram_rd_data,
  input  wire logic                      i_restore_valid,
  input  wire logic [1:0]                i_restore_lock,
  input  wire logic                      i_prog_section_erased,
  input  wire logic                      i_protection_page_erased,
  input  wire logic                      i_key_unlock_ok,
  input  wire logic                      i_allow_flags_clear,
  output logic                           o_ram_rd_en,
  output logic [10:0]                    o_ram_rd_addr,
  output logic                           o_flash_prog_en,
  output logic [`FKLS_PAGE_AW-1:0]       o_flash_prog_addr,
  output logic [31:0]                    o_flash_prog_data,
  output logic                           o_operation_in_progress,
  output logic                           o_operation_done,
  output logic                           o_operation_refused,
  output logic                           o_stall_access,
  output logic [1:0]                     o_lock_state,
  output logic                           o_allow_reprogram,
  output logic                           o_key_read_permit
);
  import fkls_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  localparam logic [12:0] WAIT_LAST = 13'(WORD_CYCLES - 1);

  fkls_state_t             state_reg;
  logic [`FKLS_OP_W-1:0]   op_reg;
  logic [12:0]             timer_reg;
  logic [5:0]              words_reg;
  logic [5:0]              index_reg;
  logic [10:0]             ptr_reg;
  logic                    data_wait_reg;
  logic [1:0]              lock_reg;
  logic                    allow_reg;
  logic                    refuse_reg;
  logic                    launch;
  logic                    known_op;
  logic                    finish;
  logic                    accept;
  logic                    word_end;

  // length field decode; zero stands for a full key
  function automatic logic [5:0] key_len(input logic [31:0] w);
    logic [4:0] f;
    f = w[`FKLS_LEN_MSB:`FKLS_LEN_LSB];
    key_len = (f == 5'h00) ? `FKLS_MAX_WORDS : {1'b0, f};
  endfunction : key_len

  // shared by sequencer and RAM port so both agree on the last word
  function automatic logic more_words(input logic [`FKLS_OP_W-1:0] op, input logic [5:0] idx,
                                      input logic [5:0] total);
    more_words = (op == `FKLS_OP_STORE_KEY) && (idx + 6'h01 < total);
  endfunction : more_words

  // ----------------------------------------
  // launch and decode
  // ----------------------------------------
  // trigger while busy is held off by the stall, so it is ignored here
  assign launch = i_execute_trigger && (state_reg == FKLS_IDLE);

  assign known_op = (i_op_select == `FKLS_OP_STORE_KEY) ||
                    (i_op_select == `FKLS_OP_PERM_LOCK) ||
                    (i_op_select == `FKLS_OP_KEY_LOCK);

  assign finish = (state_reg == FKLS_DONE);

  // a launch that passes both the code and the protection check
  assign accept   = launch && known_op && (lock_reg == `FKLS_LOCK_NONE);
  assign word_end = (state_reg == FKLS_PROG) && (timer_reg == WAIT_LAST);

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= FKLS_IDLE;
      op_reg        <= '0;
      refuse_reg    <= 1'b0;
      timer_reg     <= '0;
      words_reg     <= '0;
      index_reg     <= '0;
      ptr_reg       <= '0;
      data_wait_reg <= 1'b0;
    end else if (i_clk_en) begin
      unique case (state_reg)
        FKLS_IDLE: begin
          if (launch) begin
            op_reg    <= i_op_select;
            ptr_reg   <= i_ram_word_pointer;
            index_reg <= '0;
            words_reg <= 6'h01;
            timer_reg <= '0;
            if (!known_op || lock_reg != `FKLS_LOCK_NONE) begin
              refuse_reg <= 1'b1;
              state_reg  <= FKLS_DONE;
            end else if (i_op_select == `FKLS_OP_STORE_KEY) begin
              refuse_reg    <= 1'b0;
              data_wait_reg <= 1'b1;
              state_reg     <= FKLS_FETCH;
            end else begin
              // pointers and word count play no part here
              refuse_reg <= 1'b0;
              state_reg  <= FKLS_PROG;
            end
          end
        end
        FKLS_FETCH: begin
          // RAM answers one cycle after the read strobe
          if (data_wait_reg) begin
            data_wait_reg <= 1'b0;
          end else begin
            if (index_reg == 6'h00) begin
              words_reg <= key_len(i_ram_rd_data);
            end
            timer_reg <= '0;
            state_reg <= FKLS_PROG;
          end
        end
        FKLS_PROG: begin
          if (timer_reg == WAIT_LAST) begin
            timer_reg <= '0;
            if (more_words(op_reg, index_reg, words_reg)) begin
              index_reg     <= index_reg + 6'h01;
              ptr_reg       <= ptr_reg + 11'h001;
              data_wait_reg <= 1'b1;
              state_reg     <= FKLS_FETCH;
            end else begin
              state_reg <= FKLS_DONE;
            end
          end else begin
            timer_reg <= timer_reg + 13'h0001;
          end
        end
        FKLS_DONE: begin
          state_reg <= FKLS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // RAM read port
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ram_rd_en   <= 1'b0;
      o_ram_rd_addr <= '0;
    end else if (i_clk_en) begin
      o_ram_rd_en <= 1'b0;
      if (accept && i_op_select == `FKLS_OP_STORE_KEY) begin
        o_ram_rd_en   <= 1'b1;
        o_ram_rd_addr <= i_ram_word_pointer;
      end else if (word_end && more_words(op_reg, index_reg, words_reg)) begin
        o_ram_rd_en   <= 1'b1;
        o_ram_rd_addr <= ptr_reg + 11'h001;
      end
    end
  end

  // ----------------------------------------
  // flash program port
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flash_prog_en   <= 1'b0;
      o_flash_prog_addr <= '0;
      o_flash_prog_data <= '0;
    end else if (i_clk_en) begin
      o_flash_prog_en <= 1'b0;
      if (state_reg == FKLS_FETCH && !data_wait_reg) begin
        o_flash_prog_en   <= 1'b1;
        o_flash_prog_addr <= `FKLS_KEY_BASE + {2'b00, index_reg, 2'b00};
        o_flash_prog_data <= i_ram_rd_data;
      end else if (accept && i_op_select != `FKLS_OP_STORE_KEY) begin
        o_flash_prog_en   <= 1'b1;
        o_flash_prog_data <= `FKLS_ZERO_WORD;
        o_flash_prog_addr <= (i_op_select == `FKLS_OP_PERM_LOCK) ?
                             `FKLS_PERM_ADDR : `FKLS_KEYLOCK_ADDR;
      end
    end
  end

  // ----------------------------------------
  // protection state
  // ----------------------------------------
  // lock bits change when a lock command ends unrefused, on a restore, an allowed erase or a key unlock with the permanent bit clear;
  // a stored key alone leaves them untouched
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_reg <= `FKLS_LOCK_RESET;
    end else if (i_clk_en) begin
      if (finish && !refuse_reg && op_reg == `FKLS_OP_PERM_LOCK) begin
        lock_reg[`FKLS_PERM_BIT] <= 1'b1;
      end else if (finish && !refuse_reg && op_reg == `FKLS_OP_KEY_LOCK) begin
        lock_reg[`FKLS_KEY_BIT] <= 1'b1;
      end else if (i_restore_valid) begin
        // page contents reloaded after reset put the lock back
        lock_reg <= i_restore_lock;
      end else if (i_protection_page_erased && allow_reg) begin
        lock_reg <= `FKLS_LOCK_NONE;
      end else if (i_key_unlock_ok && !lock_reg[`FKLS_PERM_BIT]) begin
        lock_reg[`FKLS_KEY_BIT] <= 1'b0;
      end
    end
  end

  // allow flags: temporary access after a program-section erase
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      allow_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (i_prog_section_erased) begin
        allow_reg <= 1'b1;
      end else if (i_allow_flags_clear) begin
        allow_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  // done set wins over a status read in the same cycle
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_operation_in_progress <= 1'b0;
      o_operation_done        <= 1'b0;
      o_operation_refused     <= 1'b0;
      o_stall_access          <= 1'b0;
    end else if (i_clk_en) begin
      if (launch) begin
        o_operation_in_progress <= 1'b1;
        o_stall_access          <= 1'b1;
        o_operation_refused     <= 1'b0;
      end else if (finish) begin
        o_operation_in_progress <= 1'b0;
        o_stall_access          <= 1'b0;
        o_operation_refused     <= refuse_reg;
      end
      if (finish) begin
        o_operation_done <= 1'b1;
      end else if (i_status_read) begin
        o_operation_done <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // visible protection outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_lock_state      <= `FKLS_LOCK_RESET;
      o_allow_reprogram <= 1'b0;
      o_key_read_permit <= 1'b1;
    end else if (i_clk_en) begin
      o_lock_state      <= lock_reg;
      o_allow_reprogram <= allow_reg;
      o_key_read_permit <= (lock_reg == `FKLS_LOCK_NONE);
    end
  end

endmodule : fkls_top

// file: hdl/fkls_cfg.svh
// constants for the flash key and lock setup block
`ifndef FKLS_CFG_SVH
`define FKLS_CFG_SVH
// ----------------------------------------
// operation codes
// ----------------------------------------
`define FKLS_OP_W          3
`define FKLS_OP_STORE_KEY  3'h1
`define FKLS_OP_PERM_LOCK  3'h2
`define FKLS_OP_KEY_LOCK   3'h3
// ----------------------------------------
// information page byte addresses
// ----------------------------------------
`define FKLS_PAGE_AW       10
`define FKLS_KEY_BASE      10'h300
`define FKLS_PERM_ADDR     10'h208
`define FKLS_KEYLOCK_ADDR  10'h20C
// ----------------------------------------
// field positions and values
// ----------------------------------------
`define FKLS_LEN_MSB       4
`define FKLS_LEN_LSB       0
`define FKLS_MAX_WORDS     6'h20
`define FKLS_PERM_BIT      1
`define FKLS_KEY_BIT       0
`define FKLS_LOCK_NONE     2'h0
`define FKLS_LOCK_RESET    2'h0
`define FKLS_ZERO_WORD     32'h0000_0000
// ----------------------------------------
// timing
// ----------------------------------------
`define FKLS_WORD_TIME_NS  72000
`define FKLS_CLK_PERIOD_NS 10
`define FKLS_WORD_CYCLES   (`FKLS_WORD_TIME_NS / `FKLS_CLK_PERIOD_NS)
`endif

// file: hdl/fkls_pkg.sv
// types for the flash key and lock setup block
package fkls_pkg;
  typedef enum logic [3:0] {
    FKLS_IDLE  = 4'h1,
    FKLS_FETCH = 4'h2,
    FKLS_PROG  = 4'h4,
    FKLS_DONE  = 4'h8
  } fkls_state_t;
endpackage : fkls_pkg

// file: verification/fkls_chk_sva.sv
// concurrent checks on the ports of the key and lock command handler
`timescale 1ns/1ps
module fkls_chk #(
  parameter int WORD_CYCLES = 20
) (
  input wire logic        i_clock,
  input wire logic        i_rst_n,
  input wire logic        i_execute_trigger,
  input wire logic        i_status_read,
  input wire logic        o_flash_prog_en,
  input wire logic [9:0]  o_flash_prog_addr,
  input wire logic [31:0] o_flash_prog_data,
  input wire logic        o_operation_in_progress,
  input wire logic        o_operation_done,
  input wire logic        o_operation_refused,
  input wire logic        o_stall_access,
  input wire logic [1:0]  o_lock_state
);
  // lock word is programmed in the cycle busy rises, done follows one word time and one cycle later
  localparam int DONE_DLY = WORD_CYCLES + 1;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  stall_busy_a: assert property (o_stall_access == o_operation_in_progress)
    else $error("stall differs from busy");
  launch_busy_a: assert property ($rose(o_operation_in_progress) |-> $past(i_execute_trigger))
    else $error("busy rose without a launch");
  done_idle_a: assert property ($rose(o_operation_done) |-> !o_operation_in_progress && $past(o_operation_in_progress))
    else $error("done not at end of a run");
  done_clear_a: assert property (i_status_read && !o_operation_in_progress |=> !o_operation_done)
    else $error("status read left done set");
  refuse_done_a: assert property ($rose(o_operation_refused) |-> o_operation_done && $fell(o_operation_in_progress))
    else $error("refused without done");
  refuse_noprog_a: assert property ($rose(o_operation_in_progress) && o_lock_state != 2'h0 |->
    !o_flash_prog_en ##1 (o_operation_refused && o_operation_done))
    else $error("locked command not refused");
  perm_lock_a: assert property (o_flash_prog_en && o_flash_prog_addr == 10'h208 |->
    o_flash_prog_data == 32'h0 && o_operation_in_progress ##DONE_DLY o_operation_done ##1 o_lock_state[1])
    else $error("permanent lock sequence wrong");
  key_lock_a: assert property (o_flash_prog_en && o_flash_prog_addr == 10'h20C |->
    o_flash_prog_data == 32'h0 && o_operation_in_progress ##DONE_DLY o_operation_done ##1 o_lock_state[0])
    else $error("key lock sequence wrong");
  store_spacing_a: assert property (o_flash_prog_en && o_flash_prog_addr[9:8] == 2'h3 |=>
    (!o_flash_prog_en && o_lock_state == 2'h0) [*8])
    else $error("key word spacing or lock change");
endmodule : fkls_chk
bind fkls_top fkls_chk #(.WORD_CYCLES(WORD_CYCLES)) fkls_chk_i (
  .i_clock                 (i_clock),
  .i_rst_n                 (i_rst_n),
  .i_execute_trigger       (i_execute_trigger),
  .i_status_read           (i_status_read),
  .o_flash_prog_en         (o_flash_prog_en),
  .o_flash_prog_addr       (o_flash_prog_addr),
  .o_flash_prog_data       (o_flash_prog_data),
  .o_operation_in_progress (o_operation_in_progress),
  .o_operation_done        (o_operation_done),
  .o_operation_refused     (o_operation_refused),
  .o_stall_access          (o_stall_access),
  .o_lock_state            (o_lock_state)
);

// file: verification/fkls_ram_model.sv
// synchronous RAM behind the key fetch port
`timescale 1ns/1ps
module fkls_ram_model (
  input  wire logic        i_clock,
  input  wire logic        i_rd_en,
  input  wire logic [10:0] i_rd_addr,
  output logic      [31:0] o_rd_data
);
  logic [31:0] mem [0:2047];
  // outside the answer cycle the data inverts every cycle, so a capture one cycle late sees the word inverted
  always @(posedge i_clock) begin
    if (i_rd_en) o_rd_data <= mem[i_rd_addr];
    else o_rd_data <= ~o_rd_data;
  end
endmodule : fkls_ram_model

// file: verification/testbench.sv
// self-checking bench for the key and lock command handler
`timescale 1ns/1ps
`include "fkls_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic        i_clock = 1'b0, i_rst_n = 1'b0, i_clk_en = 1'b1;
  logic        i_execute_trigger = 1'b0, i_status_read = 1'b0;
  logic [2:0]  i_op_select = 3'h0;
  logic [10:0] i_ram_word_pointer = 11'h0;
  logic [31:0] i_ram_rd_data;
  logic [1:0]  i_restore_lock = 2'h2;
  logic [4:0]  ev = 5'h0;
  wire         i_restore_valid = ev[0], i_prog_section_erased = ev[1], i_protection_page_erased = ev[2];
  wire         i_key_unlock_ok = ev[3], i_allow_flags_clear = ev[4];
  logic        o_ram_rd_en, o_flash_prog_en, o_operation_in_progress, o_operation_done, o_operation_refused;
  logic        o_stall_access, o_allow_reprogram, o_key_read_permit;
  logic [10:0] o_ram_rd_addr;
  logic [9:0]  o_flash_prog_addr;
  logic [31:0] o_flash_prog_data;
  logic [1:0]  o_lock_state;
  localparam int WC = 20;
  int          miscompares = 0, compares = 0;
  int          cycles_seen = 0;
  logic [41:0] prog_q[$], exp_w;
  logic        refuse_q[$], exp_r, done_d = 1'b0;
  logic [2:0]  bad[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  fkls_top #(.WORD_CYCLES(WC)) fkls_top_i (
    .i_clock                  (i_clock),
    .i_rst_n                  (i_rst_n),
    .i_clk_en                 (i_clk_en),
    .i_op_select              (i_op_select),
    .i_execute_trigger        (i_execute_trigger),
    .i_ram_word_pointer       (i_ram_word_pointer),
    .i_status_read            (i_status_read),
    .i_ram_rd_data            (i_ram_rd_data),
    .i_restore_valid          (i_restore_valid),
    .i_restore_lock           (i_restore_lock),
    .i_prog_section_erased    (i_prog_section_erased),
    .i_protection_page_erased (i_protection_page_erased),
    .i_key_unlock_ok          (i_key_unlock_ok),
    .i_allow_flags_clear      (i_allow_flags_clear),
    .o_ram_rd_en              (o_ram_rd_en),
    .o_ram_rd_addr            (o_ram_rd_addr),
    .o_flash_prog_en          (o_flash_prog_en),
    .o_flash_prog_addr        (o_flash_prog_addr),
    .o_flash_prog_data        (o_flash_prog_data),
    .o_operation_in_progress  (o_operation_in_progress),
    .o_operation_done         (o_operation_done),
    .o_operation_refused      (o_operation_refused),
    .o_stall_access           (o_stall_access),
    .o_lock_state             (o_lock_state),
    .o_allow_reprogram        (o_allow_reprogram),
    .o_key_read_permit        (o_key_read_permit)
  );
  fkls_ram_model fkls_ram_model_i (.i_clock(i_clock), .i_rd_en(o_ram_rd_en), .i_rd_addr(o_ram_rd_addr),
                                   .o_rd_data(i_ram_rd_data));
  always #5 i_clock = ~i_clock;
  // ----------------------------------------
  // monitor: results against the oldest note
  // ----------------------------------------
  always @(posedge i_clock) begin
    done_d <= o_operation_done;
    if (o_flash_prog_en === 1'b1) begin
      exp_w = (prog_q.size() > 0) ? prog_q.pop_front() : 42'h3FF_FFFF_FFFF;
      `CHK("program word", exp_w, {o_flash_prog_addr, o_flash_prog_data})
    end
    if (o_operation_done === 1'b1 && !done_d) begin
      exp_r = (refuse_q.size() > 0) ? refuse_q.pop_front() : 1'bx;
      `CHK("refused flag", exp_r, o_operation_refused)
    end
  end
  // ----------------------------------------
  // driver tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    tick(1);
    ev <= 5'h0;
    tick(2);
  endtask : pulse
  task automatic run_cmd(input logic [2:0] op, input logic refuse);
    int k;
    refuse_q.push_back(refuse);
    i_op_select <= op;
    i_execute_trigger <= 1'b1;
    tick(1);
    i_execute_trigger <= 1'b0;
    for (k = 0; k < 2000 && o_operation_done !== 1'b1; k++) tick(1);
    cycles_seen = k;
    `CHK("done seen", 1'b1, o_operation_done)
    if (refuse) `CHK("refuse cycles", 2, cycles_seen)
    tick(1);
    i_status_read <= 1'b1;
    tick(1);
    i_status_read <= 1'b0;
    tick(2);
  endtask : run_cmd
  // key locations are taken as blank here, the model holds no old key
  task automatic store_key(input logic [4:0] len);
    int n, i;
    logic [10:0] p;
    n = (len == 5'h0) ? 32 : int'(len);
    p = 11'($urandom_range(2000));
    for (i = 0; i < 32; i++) fkls_ram_model_i.mem[p + i] = $urandom;
    fkls_ram_model_i.mem[p][4:0] = len;
    for (i = 0; i < n; i++) prog_q.push_back({10'(`FKLS_KEY_BASE + 10'(4 * i)), fkls_ram_model_i.mem[p + i]});
    i_ram_word_pointer <= p;
    run_cmd(`FKLS_OP_STORE_KEY, 1'b0);
    `CHK("store cycles", n * (WC + 2) + 2, cycles_seen)
    `CHK("lock after store", 2'h0, o_lock_state)
    `CHK("key read permit", 1'b1, o_key_read_permit)
    $display("test store key length %0d done", n);
  endtask : store_key
  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    tick(20000);
    miscompares++;
    summarize();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(62));
    tick(3);
    i_rst_n <= 1'b1;
    tick(1);
    store_key(5'h1);
    store_key(5'($urandom_range(30, 2)));
    store_key(5'h0);
    foreach (bad[j]) run_cmd(bad[j], 1'b1);
    $display("test unknown codes done");
    i_ram_word_pointer <= 11'($urandom);
    prog_q.push_back({`FKLS_KEYLOCK_ADDR, 32'h0});
    run_cmd(`FKLS_OP_KEY_LOCK, 1'b0);
    `CHK("key lock cycles", WC + 2, cycles_seen)
    `CHK("key lock bit", 2'h1, o_lock_state)
    `CHK("key read permit", 1'b0, o_key_read_permit)
    for (int j = 1; j < 4; j++) run_cmd(3'(j), 1'b1);
    pulse(3);
    `CHK("unlocked", 2'h0, o_lock_state)
    prog_q.push_back({`FKLS_PERM_ADDR, 32'h0});
    run_cmd(`FKLS_OP_PERM_LOCK, 1'b0);
    `CHK("perm lock cycles", WC + 2, cycles_seen)
    `CHK("perm lock bit", 2'h2, o_lock_state)
    pulse(3);
    `CHK("perm survives unlock", 2'h2, o_lock_state)
    pulse(1);
    `CHK("allow flag", 1'b1, o_allow_reprogram)
    pulse(2);
    `CHK("erased lock", 2'h0, o_lock_state)
    pulse(4);
    `CHK("allow cleared", 1'b0, o_allow_reprogram)
    $display("test lock and release done");
    i_rst_n <= 1'b0;
    tick(2);
    i_rst_n <= 1'b1;
    tick(1);
    `CHK("lock after reset", 2'h0, o_lock_state)
    i_clk_en <= 1'b0;
    pulse(0);
    `CHK("frozen lock", 2'h0, o_lock_state)
    i_clk_en <= 1'b1;
    pulse(0);
    `CHK("restored lock", 2'h2, o_lock_state)
    $display("test reset and restore done");
    `CHK("pending notes", 0, prog_q.size() + refuse_q.size())
    summarize();
  end
endmodule : testbench
